// ### bench/mic_checker.sv
/*
 * assertions on the mic_top ports, with a shadow of completed writes.
 * assumes one clock core_clk and the async active-low arst_n.
 */
`timescale 1ns/10ps
`default_nettype none
module mic_checker (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic core_ack,
	input wire logic core_reti,
	input wire logic irq_req,
	input wire logic [15:0] irq_vector,
	input wire logic timer0_run,
	input wire logic timer1_run,
	input wire logic timer2_overflow_flag,
	input wire logic timer2_external_flag
);
	logic [4:0] wa_reg;
	logic [7:0] wd_reg, ie_reg, ip_reg, tc_reg;
	logic hi_reg, lo_reg, aw_got_reg, w_got_reg;
	logic [7:0] ie_prev_reg;
	logic [2:0] src;
	assign src = irq_vector[5:3];
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// shadow registers at the write response, and the levels in service
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			{wa_reg, wd_reg, ie_reg, ip_reg, tc_reg, hi_reg, lo_reg} <= '0;
			{aw_got_reg, w_got_reg, ie_prev_reg} <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				wa_reg <= s_axi_awaddr;
				aw_got_reg <= 1'h1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wd_reg <= s_axi_wdata[7:0];
				w_got_reg <= 1'h1;
			end
			// a write lands the cycle after address and data are both held
			if (aw_got_reg && w_got_reg && !s_axi_bvalid) begin
				aw_got_reg <= 1'h0;
				w_got_reg <= 1'h0;
				if (wa_reg == 5'h00)
					ie_reg <= wd_reg;
				if (wa_reg == 5'h04)
					ip_reg <= wd_reg;
				if (wa_reg == 5'h08)
					tc_reg <= wd_reg;
			end
			// enables as seen by the pick that raised the request
			ie_prev_reg <= ie_reg;
			if (core_reti && hi_reg)
				hi_reg <= 1'h0;
			else if (core_reti)
				lo_reg <= 1'h0;
			if (core_ack && irq_req && ip_reg[src] && !ip_reg[7])
				hi_reg <= 1'h1;
			else if (core_ack && irq_req)
				lo_reg <= 1'h1;
		end
	end
	sequence s_ack_taken;
		core_ack && irq_req;
	endsequence
	sequence s_low_busy;
		lo_reg && irq_req;
	endsequence
	chk_vector_legal:
		assert property (irq_req |-> irq_vector inside {16'h0003, 16'h000b, 16'h0013,
			16'h001b, 16'h0023, 16'h002b}) else $error("vector outside the table");
	chk_ack_drop:
		assert property (s_ack_taken |=> !irq_req) else $error("request held after ack");
	chk_global_off:
		assert property (!ie_reg[7] [*2] |-> !irq_req) else $error("request with global off");
	chk_source_gate:
		assert property (irq_req |-> ie_prev_reg[src]) else $error("request from disabled source");
	chk_run_follow:
		assert property ($stable(tc_reg) |-> timer0_run == tc_reg[4] && timer1_run == tc_reg[6])
		else $error("run bit differs from write");
	chk_high_blocks:
		assert property (hi_reg |-> !irq_req) else $error("request during high service");
	chk_low_blocks:
		assert property (s_low_busy |-> ip_reg[src] && !ip_reg[7])
		else $error("low request during low service");
	chk_t2_cause:
		assert property (irq_req && irq_vector == 16'h002b |->
			$past(timer2_overflow_flag) || $past(timer2_external_flag))
		else $error("timer 2 request without flag");
endmodule // mic_checker
bind mic_top mic_checker i_chk (.core_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.core_ack, .core_reti, .irq_req, .irq_vector, .timer0_run, .timer1_run,
	.timer2_overflow_flag, .timer2_external_flag);
`default_nettype wire

// ### bench/mic_core_model.sv
/*
 * model of the processor core that serves the interrupt control block.
 * assumes mic_top on the same core_clk; svc_len sets how long a routine runs.
 */
`timescale 1ns/10ps
`default_nettype none
module mic_core_model (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic irq_req,
	input wire logic [15:0] irq_vector,
	input wire logic [7:0] svc_len,
	output logic core_ack,
	output logic core_reti,
	output logic [15:0] got_vec,
	output int n_ack,
	output int depth
);
	logic [7:0] cnt_reg;
	// ack a shown request, run the routine, then return; nesting is counted
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			{core_ack, core_reti, got_vec, n_ack, depth, cnt_reg} <= '0;
		end else begin
			core_ack <= irq_req && !core_ack;
			core_reti <= 1'h0;
			if (core_ack && irq_req) begin
				got_vec <= irq_vector;
				n_ack <= n_ack + 1;
				depth <= depth + 1;
				cnt_reg <= svc_len;
			end else if (depth > 0 && cnt_reg > 8'h01) begin
				cnt_reg <= cnt_reg - 8'h01;
			end else if (depth > 0) begin
				core_reti <= 1'h1;
				depth <= depth - 1;
				cnt_reg <= svc_len;
			end
		end
	end
endmodule // mic_core_model
`default_nettype wire

// ### bench/tb_top.sv
/*
 * self-checking bench for mic_top with a core model on its far side.
 * assumes a 10 MHz core_clk and registers reached over axi4-lite.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic core_clk = 1'h0, arst_n = 1'h0;
	logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic ext0_pin = 1'h1, ext1_pin = 1'h1, timer0_overflow = 1'h0, timer1_overflow = 1'h0;
	logic serial_rx_flag = 1'h0, serial_tx_flag = 1'h0;
	logic timer2_overflow_flag = 1'h0, timer2_external_flag = 1'h0;
	logic [7:0] svc_len = 8'h06;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire core_ack, core_reti, irq_req, timer0_run, timer1_run, irq;
	wire [15:0] irq_vector, got_vec;
	int n_ack, depth, err_count = 0, n_compared = 0;
	mic_top i_dut (.core_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext0_pin, .ext1_pin,
		.timer0_overflow, .timer1_overflow, .serial_rx_flag, .serial_tx_flag,
		.timer2_overflow_flag, .timer2_external_flag, .core_ack, .core_reti, .irq_req,
		.irq_vector, .timer0_run, .timer1_run, .irq);
	mic_core_model i_core (.core_clk, .arst_n, .irq_req, .irq_vector, .svc_len,
		.core_ack, .core_reti, .got_vec, .n_ack, .depth);
	// 100 ns clock
	always #50 core_clk = ~core_clk;
	// verdict and end of run
	task automatic test_done;
		$display("compared %0d mismatched %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic bail;
		err_count++;
		test_done;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// bus write: address and data offered together, held until taken
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
			n++;
		end while (!s_axi_bvalid && n < 50);
		s_axi_bready <= 1'h0;
		chk("write resp", (a > 5'h14) ? 32'h2 : 32'h0, {30'h0, s_axi_bresp});
		@(posedge core_clk);
		if (n >= 50)
			bail;
	endtask
	// bus read: data and response taken at the rvalid edge
	task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge core_clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
			n++;
		end while (!s_axi_rvalid && n < 50);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
		@(posedge core_clk);
		if (n >= 50)
			bail;
	endtask
	task automatic rc(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk("read data", e, d);
		chk("read resp", 32'h0, {30'h0, r});
	endtask
	task automatic wait_ack(input int k);
		int n;
		n = 0;
		while (n_ack == k && n < 300) begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 300)
			bail;
	endtask
	// reset values, unmapped read, run bits
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0] r;
		rc(5'h00, 32'h0);
		rc(5'h04, 32'h0);
		rc(5'h08, 32'h0);
		rd(5'h18, d, r);
		chk("unmapped resp", 32'h2, {30'h0, r});
		wr(5'h18, 8'hff);
		wr(5'h08, 8'h50);
		cyc(2);
		chk("run bits", 32'h3, {30'h0, timer1_run, timer0_run});
		wr(5'h08, 8'h00);
		cyc(2);
		chk("run bits", 32'h0, {30'h0, timer1_run, timer0_run});
		wr(5'h04, 8'hbf);
		rc(5'h04, 32'hbf);
		wr(5'h04, 8'h00);
		$display("register test done");
	endtask
	// timer 0 overflow: flag, global gate, vector, auto clear, interrupt line
	task automatic t_timer0;
		int k;
		wr(5'h00, 8'h02);
		wr(5'h10, 8'h02);
		timer0_overflow <= 1'h1;
		@(posedge core_clk);
		timer0_overflow <= 1'h0;
		cyc(4);
		chk("irq_req", 32'h0, {31'h0, irq_req});
		rc(5'h08, 32'h20);
		k = n_ack;
		wr(5'h00, 8'h82);
		wait_ack(k);
		chk("vector", 32'h000b, {16'h0, got_vec});
		rc(5'h08, 32'h00);
		chk("irq", 32'h1, {31'h0, irq});
		wr(5'h10, 8'h00);
		cyc(2);
		chk("irq", 32'h0, {31'h0, irq});
		wr(5'h10, 8'h02);
		cyc(2);
		chk("irq", 32'h1, {31'h0, irq});
		wr(5'h0c, 8'h3f);
		cyc(2);
		chk("irq", 32'h0, {31'h0, irq});
		rc(5'h0c, 32'h0);
		$display("timer test done");
	endtask
	// simultaneous serial and timer 2 requests under three priority settings
	task automatic t_order;
		int k;
		logic [23:0] ipv;
		ipv = 24'ha02000;
		serial_rx_flag <= 1'h1;
		timer2_external_flag <= 1'h1;
		for (int i = 0; i < 3; i++) begin
			wr(5'h00, 8'h00);
			cyc(20);
			wr(5'h04, ipv[8*i +: 8]);
			k = n_ack;
			wr(5'h00, 8'hb0);
			wait_ack(k);
			chk("vector", (i == 1) ? 32'h002b : 32'h0023, {16'h0, got_vec});
		end
		wr(5'h00, 8'h00);
		serial_rx_flag <= 1'h0;
		timer2_external_flag <= 1'h0;
		cyc(20);
		$display("order test done");
	endtask
	// high timer 2 request preempts a low serial routine
	task automatic t_nest;
		int k;
		svc_len <= 8'h28;
		wr(5'h04, 8'h20);
		serial_tx_flag <= 1'h1;
		k = n_ack;
		wr(5'h00, 8'h90);
		wait_ack(k);
		chk("vector", 32'h0023, {16'h0, got_vec});
		timer2_overflow_flag <= 1'h1;
		wr(5'h00, 8'hb0);
		wait_ack(k + 1);
		chk("vector", 32'h002b, {16'h0, got_vec});
		chk("depth", 32'h2, depth);
		wr(5'h00, 8'h00);
		serial_tx_flag <= 1'h0;
		timer2_overflow_flag <= 1'h0;
		cyc(150);
		svc_len <= 8'h06;
		wr(5'h04, 8'h00);
		$display("nesting test done");
	endtask
	// external pin 0 in level and in falling edge mode
	task automatic t_ext;
		int k;
		ext0_pin <= 1'h0;
		cyc(6);
		rc(5'h08, 32'h02);
		ext0_pin <= 1'h1;
		cyc(6);
		rc(5'h08, 32'h00);
		wr(5'h08, 8'h01);
		ext0_pin <= 1'h0;
		cyc(3);
		ext0_pin <= 1'h1;
		cyc(6);
		rc(5'h08, 32'h03);
		k = n_ack;
		wr(5'h00, 8'h81);
		wait_ack(k);
		chk("vector", 32'h0003, {16'h0, got_vec});
		cyc(2);
		rc(5'h08, 32'h01);
		wr(5'h00, 8'h00);
		$display("external test done");
	endtask
	// ext1 level request against timer 1 overflow, then timer 1 alone
	task automatic t_pair;
		int k;
		ext1_pin <= 1'h0;
		timer1_overflow <= 1'h1;
		@(posedge core_clk);
		timer1_overflow <= 1'h0;
		cyc(4);
		k = n_ack;
		wr(5'h00, 8'h8c);
		wait_ack(k);
		chk("vector", 32'h0013, {16'h0, got_vec});
		ext1_pin <= 1'h1;
		wait_ack(k + 1);
		chk("vector", 32'h001b, {16'h0, got_vec});
		cyc(2);
		rc(5'h08, 32'h01);
		wr(5'h00, 8'h00);
		$display("pair test done");
	endtask
	// reset for ten cycles, then the scenarios
	initial begin
		cyc(10);
		arst_n <= 1'h1;
		@(posedge core_clk);
		t_regs;
		t_timer0;
		t_order;
		t_nest;
		t_ext;
		t_pair;
		test_done;
	end
endmodule // tb_top
`default_nettype wire

// ### inc/mic_defs.vh
/*
 * constants of the interrupt control block: register offsets, bit
 * positions, reset values and vector addresses.
 * assumes inclusion by bare name from the design files only.
 */
`ifndef MIC_DEFS_VH
`define MIC_DEFS_VH

// register byte offsets on the bus
`define MIC_OFS_ENABLE 5'h00
`define MIC_OFS_PRIORITY 5'h04
`define MIC_OFS_TIMER_CTRL 5'h08
`define MIC_OFS_EVT_STATUS 5'h0c
`define MIC_OFS_EVT_MASK 5'h10
`define MIC_OFS_CORE_STATE 5'h14

// enable register fields
`define MIC_IE_GLOBAL 7
`define MIC_IE_RESERVED 6
// priority register fields
`define MIC_IP_FLAT 7
`define MIC_IP_RESERVED 6
// writable bits of enable and priority (reserved bit reads zero)
`define MIC_IE_IP_WMASK 8'hbf

// timer control register fields
`define MIC_TC_T1_OVF 7
`define MIC_TC_T1_RUN 6
`define MIC_TC_T0_OVF 5
`define MIC_TC_T0_RUN 4
`define MIC_TC_X1_FLAG 3
`define MIC_TC_X1_TYPE 2
`define MIC_TC_X0_FLAG 1
`define MIC_TC_X0_TYPE 0

// source indices, also the fixed in-level order
`define MIC_SRC_EXT0 3'h0
`define MIC_SRC_T0 3'h1
`define MIC_SRC_EXT1 3'h2
`define MIC_SRC_T1 3'h3
`define MIC_SRC_SER 3'h4
`define MIC_SRC_T2 3'h5
`define MIC_NSRC 6

// vector addresses
`define MIC_VEC_EXT0 16'h0003
`define MIC_VEC_T0 16'h000b
`define MIC_VEC_EXT1 16'h0013
`define MIC_VEC_T1 16'h001b
`define MIC_VEC_SER 16'h0023
`define MIC_VEC_T2 16'h002b

// reset values
`define MIC_RST_ENABLE 8'h00
`define MIC_RST_PRIORITY 8'h00
`define MIC_RST_TIMER_CTRL 8'h00
`define MIC_RST_MASK 6'h00

// bus answers
`define MIC_RESP_OKAY 2'h0
`define MIC_RESP_SLVERR 2'h2

`endif

// ### verilog/mic_ext_det.v
/*
 * external request detector for one pin: low level or falling edge.
 * assumes a pin already synchronised to core_clk.
 */
`timescale 1ns/10ps
`default_nettype none

module mic_ext_det (
	input wire core_clk,
	input wire arst_n,
	input wire pin_sync,
	input wire trig_edge,
	input wire svc_clr,
	input wire sw_wr,
	input wire sw_val,
	output wire req_flag
);

	reg prev_reg;
	reg flag_reg;
	reg flag_next;
	wire fall;

	assign fall = prev_reg & ~pin_sync;

	// flag update: edge latches, level follows pin
	always @* begin
		flag_next = flag_reg;
		if (!trig_edge) begin
			flag_next = ~pin_sync;
		end else begin
			if (sw_wr)
				flag_next = sw_val;
			if (svc_clr)
				flag_next = 1'b0;
			if (fall)
				flag_next = 1'b1; // set wins over clear
		end
	end

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			prev_reg <= 1'b1;
			flag_reg <= 1'b0;
		end else begin
			prev_reg <= pin_sync;
			flag_reg <= flag_next;
		end
	end

	assign req_flag = flag_reg;

endmodule // mic_ext_det
`default_nettype wire

// ### verilog/mic_sync.v
/*
 * two-stage synchroniser for pin levels, one bit per lane.
 * assumes pins idle high; both stages reset to one.
 */
`timescale 1ns/10ps
`default_nettype none

module mic_sync #(
	parameter WIDTH = 2
) (
	input wire core_clk,
	input wire arst_n,
	input wire [WIDTH-1:0] pin_async,
	output wire [WIDTH-1:0] pin_sync
);

	reg [WIDTH-1:0] stage1_reg;
	reg [WIDTH-1:0] stage2_reg;

	// first stage feeds only the second
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			stage1_reg <= {WIDTH{1'b1}};
			stage2_reg <= {WIDTH{1'b1}};
		end else begin
			stage1_reg <= pin_async;
			stage2_reg <= stage1_reg;
		end
	end

	assign pin_sync = stage2_reg;

endmodule // mic_sync
`default_nettype wire

// ### verilog/mic_top.v
/*
 * interrupt control block: six sources, enables, two priority levels,
 * fixed in-level order, vector hand-off to the core, axi4-lite registers.
 * assumes one clock core_clk; timer, serial and timer 2 flags come from
 * logic on the same clock; external pins are asynchronous.
 */
`timescale 1ns/10ps
`default_nettype none
`include "mic_defs.vh"

// Functional notes
// - global enable clear means no new request is raised; a request already raised can still be taken the cycle after the clear.
// - each source gated by its own enable bit, order ext0,t0,ext1,t1,ser,t2.
// - acknowledged source presents its fixed vector address 0003h..002bh.
// - trigger type bit: zero low level, one falling edge.
// - external flags set on detected trigger; edge mode clears them when serviced, level mode follows the pin.
// - timer 0/1 overflow flags set on overflow, cleared on vectoring.
// - timer control holds software run bits for timers 0 and 1.
// - priority bit one selects high level, zero low level.
// - active routine blocks same or lower level requests.
// - equal-level requests resolved by fixed source order.
// - flat priority bit puts all sources on one level.
// - timer 2 enable gates combined overflow or external flag.
module mic_top (
	input wire core_clk,
	input wire arst_n,
	input wire [4:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [4:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire ext0_pin,
	input wire ext1_pin,
	input wire timer0_overflow,
	input wire timer1_overflow,
	input wire serial_rx_flag,
	input wire serial_tx_flag,
	input wire timer2_overflow_flag,
	input wire timer2_external_flag,
	input wire core_ack,
	input wire core_reti,
	output wire irq_req,
	output wire [15:0] irq_vector,
	output wire timer0_run,
	output wire timer1_run,
	output wire irq
);

	// bus slave state
	reg awready_reg;
	reg wready_reg;
	reg bvalid_reg;
	reg [1:0] bresp_reg;
	reg arready_reg;
	reg rvalid_reg;
	reg [1:0] rresp_reg;
	reg [31:0] rdata_reg;
	reg aw_full_reg;
	reg w_full_reg;
	reg [4:0] waddr_reg;
	reg [31:0] wdata_reg;
	reg [3:0] wstrb_reg;
	// registers
	reg [7:0] interrupt_enable_reg;
	reg [7:0] irq_priority_reg;
	reg timer0_run_reg;
	reg timer1_run_reg;
	reg ext0_trigger_type_reg;
	reg ext1_trigger_type_reg;
	reg timer0_overflow_flag_reg;
	reg timer1_overflow_flag_reg;
	reg [5:0] evt_status_reg;
	reg [5:0] evt_mask_reg;
	reg irq_out_reg;
	// arbitration state
	reg irq_req_reg;
	reg [15:0] irq_vector_reg;
	reg [2:0] sel_src_reg;
	reg sel_high_reg;
	reg act_high_reg;
	reg act_low_reg;
	reg [5:0] pend_prev_reg;

	wire [1:0] pin_sync;
	wire ext0_request_flag;
	wire ext1_request_flag;
	wire wr_go;
	wire wr_lane0;
	wire wr_enable;
	wire wr_priority;
	wire wr_tctrl;
	wire wr_status;
	wire wr_mask;
	wire ack_take;
	wire [7:0] timer_ctrl_reg;
	wire [5:0] pend;
	wire [5:0] elig;
	wire [5:0] src_high;
	wire [5:0] cand_high;
	wire [5:0] cand_low;
	wire flat_priority_select;
	wire global_irq_enable;
	reg cand_valid;
	reg cand_is_high;
	reg [2:0] cand_src;
	reg [15:0] cand_vec;
	reg [5:0] pick_set;
	reg [31:0] rd_mux;
	reg rd_hit;
	integer i;

	// pins cross into core_clk
	mic_sync #(
		.WIDTH(2)
	) u_sync (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.pin_async({ext1_pin, ext0_pin}),
		.pin_sync(pin_sync)
	);

	// write decode; only byte lane 0 carries register bits
	assign wr_go = aw_full_reg & w_full_reg & ~bvalid_reg;
	assign wr_lane0 = wr_go & wstrb_reg[0];
	assign wr_enable = wr_lane0 && (waddr_reg == `MIC_OFS_ENABLE);
	assign wr_priority = wr_lane0 && (waddr_reg == `MIC_OFS_PRIORITY);
	assign wr_tctrl = wr_lane0 && (waddr_reg == `MIC_OFS_TIMER_CTRL);
	assign wr_status = wr_lane0 && (waddr_reg == `MIC_OFS_EVT_STATUS);
	assign wr_mask = wr_lane0 && (waddr_reg == `MIC_OFS_EVT_MASK);
	assign ack_take = core_ack & irq_req_reg;

	mic_ext_det u_ext0 (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.pin_sync(pin_sync[0]),
		.trig_edge(ext0_trigger_type_reg),
		.svc_clr(ack_take && (sel_src_reg == `MIC_SRC_EXT0)),
		.sw_wr(wr_tctrl),
		.sw_val(wdata_reg[`MIC_TC_X0_FLAG]),
		.req_flag(ext0_request_flag)
	);

	mic_ext_det u_ext1 (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.pin_sync(pin_sync[1]),
		.trig_edge(ext1_trigger_type_reg),
		.svc_clr(ack_take && (sel_src_reg == `MIC_SRC_EXT1)),
		.sw_wr(wr_tctrl),
		.sw_val(wdata_reg[`MIC_TC_X1_FLAG]),
		.req_flag(ext1_request_flag)
	);

	// timer control image as software sees it
	assign timer_ctrl_reg = {timer1_overflow_flag_reg, timer1_run_reg,
		timer0_overflow_flag_reg, timer0_run_reg,
		ext1_request_flag, ext1_trigger_type_reg,
		ext0_request_flag, ext0_trigger_type_reg};

	// pending sources in fixed order
	// timer 2 combined request
	assign pend = {timer2_overflow_flag | timer2_external_flag,
		serial_rx_flag | serial_tx_flag,
		timer1_overflow_flag_reg, ext1_request_flag,
		timer0_overflow_flag_reg, ext0_request_flag};

	assign global_irq_enable = interrupt_enable_reg[`MIC_IE_GLOBAL];
	assign elig = pend & interrupt_enable_reg[5:0] & {6{global_irq_enable}};

	// flat select drops every source to low level
	assign flat_priority_select = irq_priority_reg[`MIC_IP_FLAT];
	assign src_high = irq_priority_reg[5:0] & {6{~flat_priority_select}};

	// active routine blocks same and lower level
	assign cand_high = elig & src_high & {6{~act_high_reg}};
	assign cand_low = elig & ~src_high & {6{~act_high_reg & ~act_low_reg}};

	// choose the highest-ranked candidate
	always @* begin
		cand_is_high = |cand_high;
		cand_valid = |cand_high | |cand_low;
		pick_set = cand_is_high ? cand_high : cand_low;
		cand_src = `MIC_SRC_EXT0;
		for (i = `MIC_NSRC - 1; i >= 0; i = i - 1) begin
			if (pick_set[i])
				cand_src = i[2:0];
		end
	end

	always @* begin
		case (cand_src)
		`MIC_SRC_EXT0: cand_vec = `MIC_VEC_EXT0;
		`MIC_SRC_T0: cand_vec = `MIC_VEC_T0;
		`MIC_SRC_EXT1: cand_vec = `MIC_VEC_EXT1;
		`MIC_SRC_T1: cand_vec = `MIC_VEC_T1;
		`MIC_SRC_SER: cand_vec = `MIC_VEC_SER;
		`MIC_SRC_T2: cand_vec = `MIC_VEC_T2;
		default: cand_vec = `MIC_VEC_EXT0;
		endcase
	end

	// request strobe and active levels toward the core
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_req_reg <= 1'b0;
			irq_vector_reg <= `MIC_VEC_EXT0;
			sel_src_reg <= `MIC_SRC_EXT0;
			sel_high_reg <= 1'b0;
			act_high_reg <= 1'b0;
			act_low_reg <= 1'b0;
		end else begin
			// return closes the innermost level
			if (core_reti) begin
				if (act_high_reg)
					act_high_reg <= 1'b0;
				else
					act_low_reg <= 1'b0;
			end
			if (ack_take) begin
				irq_req_reg <= 1'b0;
				if (sel_high_reg)
					act_high_reg <= 1'b1;
				else
					act_low_reg <= 1'b1;
			end else begin
				irq_req_reg <= cand_valid;
				if (cand_valid) begin
					irq_vector_reg <= cand_vec;
					sel_src_reg <= cand_src;
					sel_high_reg <= cand_is_high;
				end
			end
		end
	end

	// timer control bits and timer overflow flags
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			timer0_run_reg <= 1'b0;
			timer1_run_reg <= 1'b0;
			ext0_trigger_type_reg <= 1'b0;
			ext1_trigger_type_reg <= 1'b0;
			timer0_overflow_flag_reg <= 1'b0;
			timer1_overflow_flag_reg <= 1'b0;
		end else begin
			if (wr_tctrl) begin
				timer0_run_reg <= wdata_reg[`MIC_TC_T0_RUN];
				timer1_run_reg <= wdata_reg[`MIC_TC_T1_RUN];
				ext0_trigger_type_reg <= wdata_reg[`MIC_TC_X0_TYPE];
				ext1_trigger_type_reg <= wdata_reg[`MIC_TC_X1_TYPE];
				timer0_overflow_flag_reg <= wdata_reg[`MIC_TC_T0_OVF];
				timer1_overflow_flag_reg <= wdata_reg[`MIC_TC_T1_OVF];
			end
			if (ack_take && (sel_src_reg == `MIC_SRC_T0))
				timer0_overflow_flag_reg <= 1'b0;
			if (ack_take && (sel_src_reg == `MIC_SRC_T1))
				timer1_overflow_flag_reg <= 1'b0;
			if (timer0_overflow)
				timer0_overflow_flag_reg <= 1'b1;
			if (timer1_overflow)
				timer1_overflow_flag_reg <= 1'b1;
		end
	end

	// enable, priority, event status and mask
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			interrupt_enable_reg <= `MIC_RST_ENABLE;
			irq_priority_reg <= `MIC_RST_PRIORITY;
			evt_status_reg <= 6'h00;
			evt_mask_reg <= `MIC_RST_MASK;
			pend_prev_reg <= 6'h00;
			irq_out_reg <= 1'b0;
		end else begin
			if (wr_enable)
				interrupt_enable_reg <= wdata_reg[7:0] & `MIC_IE_IP_WMASK;
			if (wr_priority)
				irq_priority_reg <= wdata_reg[7:0] & `MIC_IE_IP_WMASK;
			if (wr_mask)
				evt_mask_reg <= wdata_reg[5:0];
			// rising request sets sticky bit; set wins over write-one clear
			pend_prev_reg <= pend;
			evt_status_reg <= (evt_status_reg & ~(wdata_reg[5:0] & {6{wr_status}}))
				| (pend & ~pend_prev_reg);
			irq_out_reg <= |(evt_status_reg & evt_mask_reg);
		end
	end

	// read mux
	always @* begin
		rd_hit = 1'b1;
		rd_mux = 32'h0000_0000;
		case (s_axi_araddr)
		`MIC_OFS_ENABLE: rd_mux = {24'h00_0000, interrupt_enable_reg};
		`MIC_OFS_PRIORITY: rd_mux = {24'h00_0000, irq_priority_reg};
		`MIC_OFS_TIMER_CTRL: rd_mux = {24'h00_0000, timer_ctrl_reg};
		`MIC_OFS_EVT_STATUS: rd_mux = {26'h000_0000, evt_status_reg};
		`MIC_OFS_EVT_MASK: rd_mux = {26'h000_0000, evt_mask_reg};
		`MIC_OFS_CORE_STATE: rd_mux = {irq_vector_reg, 8'h00, act_high_reg,
			act_low_reg, sel_high_reg, irq_req_reg, 1'b0, sel_src_reg};
		default: rd_hit = 1'b0;
		endcase
	end

	// axi4-lite write: address and data in any order, then response
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			waddr_reg <= 5'h00;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `MIC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && awready_reg) begin
				aw_full_reg <= 1'b1;
				waddr_reg <= s_axi_awaddr;
				awready_reg <= 1'b0;
			end
			if (s_axi_wvalid && wready_reg) begin
				w_full_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
				wready_reg <= 1'b0;
			end
			if (wr_go) begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				// unmapped or misaligned address answers slverr
				if (waddr_reg[1:0] != 2'h0 || waddr_reg > `MIC_OFS_CORE_STATE)
					bresp_reg <= `MIC_RESP_SLVERR;
				else
					bresp_reg <= `MIC_RESP_OKAY;
			end
			if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg <= 1'b1;
			end
		end
	end

	// axi4-lite read: one outstanding, data one cycle after address
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= `MIC_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && arready_reg) begin
				arready_reg <= 1'b0;
				rvalid_reg <= 1'b1;
				rdata_reg <= rd_mux;
				rresp_reg <= rd_hit ? `MIC_RESP_OKAY : `MIC_RESP_SLVERR;
			end
			if (rvalid_reg && s_axi_rready) begin
				rvalid_reg <= 1'b0;
				arready_reg <= 1'b1;
			end
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign irq_req = irq_req_reg;
	assign irq_vector = irq_vector_reg;
	assign timer0_run = timer0_run_reg;
	assign timer1_run = timer1_run_reg;
	assign irq = irq_out_reg;

endmodule // mic_top
`default_nettype wire
